// File: common/sewp_pkg.sv
// Summary of operation
// - unmatched select byte: release the bus, stay idle until next start
// - matched select byte: acknowledge in ninth slot, then expect address if rw is zero
// - address byte after acknowledged select is acknowledged too
// - array address is select bit b1 above the eight address bits
// - ident page access: type 1011b, address bit7 zero, low nibble picks byte
// - lock command: type 1011b, address bit7 one, data bit1 one
// - write is start, select with rw zero, address, then data bytes
// - write cycle starts only for a stop in the tenth slot
// - while writing, data line stays released, all requests ignored
// - after writing, address counter points past last modified byte
// - write protect high: no write, data bytes not acknowledged
// - byte write is one data byte, acknowledged only if unprotected
// - page write takes one to sixteen bytes of one page
// - bytes beyond page end wrap to page start, overwriting earlier ones
// - in-page address advances after every acknowledged data byte, except in a lock command
// - separate sixteen byte ident page, first three bytes hold codes
// - successful lock makes the ident page read-only until the next reset
// - locked ident page: data bytes refused, page left unchanged
// - select during write cycle is refused, accepted once finished
// - main array is 512 bytes as 32 pages of 16 bytes
// - select matches type 1010b or 1011b and both chip select pins
// - with write protect high, select and address still acknowledged
// - every byte travels most significant bit first
package sewp_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int WRITE_CYCLE_TIME_NS = 4000000;
	// a longest time, so the count rounds down
	localparam int WRITE_CYCLES_DFLT = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	localparam int PAGE_BYTES = 16;
	localparam int ARRAY_BYTES = 512;
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_IDENT = 4'hB;
	localparam int SEL_RW_BIT = 0;
	localparam int SEL_TOP_BIT = 1;
	localparam int SEL_CS_LO_BIT = 2;
	localparam int SEL_CS_HI_BIT = 3;
	localparam int ADDR_KIND_BIT = 7;
	localparam int LOCK_DATA_BIT = 1;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [2:0] CSYNC_IDLE = 3'h6;
	typedef enum logic [1:0] {L_IDLE, L_SEL, L_ADDR, L_DATA} sewp_link_state_t;
	typedef enum logic {W_IDLE, W_BUSY} sewp_wr_state_t;
	typedef struct packed {
		logic ok;
		logic is_ident;
		logic is_lock;
		logic lock_req;
		logic [4:0] page;
		logic [3:0] last_off;
		logic [PAGE_BYTES-1:0] mask;
	} sewp_pend_t;
endpackage

// File: rtl/sewp_top.sv
`timescale 1ns/10ps
module sewp_top #(
	parameter int WRITE_CYCLES = sewp_pkg::WRITE_CYCLES_DFLT,
	// identification code values are arbitrary
	parameter logic [7:0] ID_MAKER = 8'h5A,
	parameter logic [7:0] ID_FAMILY = 8'hC3,
	parameter logic [7:0] ID_DENSITY = 8'h3C
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl_link,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic write_protect_in,
	input wire logic chip_sel_hi_pin,
	input wire logic chip_sel_lo_pin,
	input wire logic [8:0] peek_addr,
	input wire logic peek_ident,
	output logic [7:0] peek_data,
	output logic write_busy,
	output logic ident_locked,
	output logic [8:0] addr_count
);
	localparam logic [sewp_pkg::CNT_W-1:0] WCNT_LAST =
		sewp_pkg::CNT_W'(WRITE_CYCLES - 1);
	localparam logic [sewp_pkg::CNT_W-1:0] WCNT_PAGE =
		sewp_pkg::CNT_W'(sewp_pkg::PAGE_BYTES);

	function automatic logic sel_match(input logic [7:0] b,
		input logic hi, input logic lo);
		sel_match = (b[7:4] == sewp_pkg::TYPE_ARRAY ||
			b[7:4] == sewp_pkg::TYPE_IDENT) &&
			b[sewp_pkg::SEL_CS_HI_BIT] == hi &&
			b[sewp_pkg::SEL_CS_LO_BIT] == lo;
	endfunction

	sewp_pkg::sewp_link_state_t lstate_r;
	sewp_pkg::sewp_wr_state_t wstate_r;
	sewp_pkg::sewp_pend_t pend_r;
	sewp_pkg::sewp_pend_t desc_r;
	logic [4:0] lsync1_r;
	logic [4:0] lsync2_r;
	logic wp_s;
	logic hi_s;
	logic lo_s;
	logic busy_s;
	logic locked_s;
	logic bit_r;
	logic start_det;
	logic start_tgl_r;
	logic start_seen_r;
	logic [7:0] byte_val;
	logic byte_done;
	logic [3:0] bitcnt_r;
	logic [7:0] shift_r;
	logic top_r;
	logic [3:0] cur_off_r;
	logic ack_nxt;
	logic refuse;
	logic stop_ok_r;
	logic [7:0] page_buf_r [sewp_pkg::PAGE_BYTES];
	logic [2:0] csync1_r;
	logic [2:0] csync2_r;
	logic [1:0] cprev_r;
	logic stop_det;
	logic commit;
	logic done;
	logic [sewp_pkg::CNT_W-1:0] wcnt_r;
	logic [3:0] widx;
	logic wr_en;
	logic [7:0] mem_r [sewp_pkg::ARRAY_BYTES];
	logic [7:0] id_r [sewp_pkg::PAGE_BYTES];

	// link side: scl is the clock, bits are committed at its falling edge
	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			lsync1_r <= 5'h00;
			lsync2_r <= 5'h00;
		end else begin
			lsync1_r <= {write_protect_in, chip_sel_hi_pin, chip_sel_lo_pin,
				write_busy, ident_locked};
			lsync2_r <= lsync1_r;
		end
	end
	assign wp_s = lsync2_r[4];
	assign hi_s = lsync2_r[3];
	assign lo_s = lsync2_r[2];
	assign busy_s = lsync2_r[1];
	assign locked_s = lsync2_r[0];

	always_ff @(posedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			bit_r <= 1'b1;
		end else begin
			bit_r <= sda_i;
		end
	end

	// a start may follow a stop with no scl edge between them, so the
	// falling sda edge itself is caught; it leads the scl fall by half
	// a period, which is the margin this crossing relies upon
	always_ff @(negedge sda_i or negedge rst_b) begin
		if (!rst_b) begin
			start_tgl_r <= 1'b0;
		end else if (scl_link) begin
			start_tgl_r <= !start_tgl_r;
		end
	end

	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			start_seen_r <= 1'b0;
		end else begin
			start_seen_r <= start_tgl_r;
		end
	end

	assign start_det = start_tgl_r != start_seen_r;
	assign byte_val = {shift_r[6:0], bit_r};
	assign byte_done = bitcnt_r == sewp_pkg::LAST_BIT && !start_det;
	assign refuse = wp_s || (pend_r.is_ident && locked_s);

	always_comb begin
		ack_nxt = 1'b0;
		case (lstate_r)
		sewp_pkg::L_SEL: ack_nxt = sel_match(byte_val, hi_s, lo_s) &&
			!busy_s;
		sewp_pkg::L_ADDR: ack_nxt = 1'b1;
		sewp_pkg::L_DATA: ack_nxt = !refuse;
		default: ack_nxt = 1'b0;
		endcase
	end

	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			bitcnt_r <= 4'h0;
			shift_r <= 8'h00;
		end else if (start_det || bitcnt_r == sewp_pkg::ACK_SLOT) begin
			bitcnt_r <= 4'h0;
		end else begin
			bitcnt_r <= bitcnt_r + 4'h1;
			shift_r <= byte_val;
		end
	end

	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			lstate_r <= sewp_pkg::L_IDLE;
		end else if (start_det) begin
			lstate_r <= sewp_pkg::L_SEL;
		end else if (byte_done) begin
			case (lstate_r)
			sewp_pkg::L_SEL: begin
				// reads are acknowledged but not served here
				if (ack_nxt && !byte_val[sewp_pkg::SEL_RW_BIT]) begin
					lstate_r <= sewp_pkg::L_ADDR;
				end else begin
					lstate_r <= sewp_pkg::L_IDLE;
				end
			end
			sewp_pkg::L_ADDR: lstate_r <= sewp_pkg::L_DATA;
			default: lstate_r <= lstate_r;
			endcase
		end
	end

	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			top_r <= 1'b0;
			cur_off_r <= 4'h0;
			pend_r <= '0;
		end else if (start_det) begin
			pend_r <= '0;
		end else if (byte_done) begin
			case (lstate_r)
			sewp_pkg::L_SEL: begin
				top_r <= byte_val[sewp_pkg::SEL_TOP_BIT];
				pend_r.is_ident <= byte_val[7:4] == sewp_pkg::TYPE_IDENT;
			end
			sewp_pkg::L_ADDR: begin
				cur_off_r <= byte_val[3:0];
				pend_r.page <= {top_r, byte_val[7:4]};
				pend_r.is_lock <= pend_r.is_ident &&
					byte_val[sewp_pkg::ADDR_KIND_BIT];
			end
			sewp_pkg::L_DATA: begin
				if (ack_nxt) begin
					pend_r.ok <= 1'b1;
					if (pend_r.is_lock) begin
						pend_r.lock_req <= pend_r.lock_req ||
							byte_val[sewp_pkg::LOCK_DATA_BIT];
					end else begin
						pend_r.mask[cur_off_r] <= 1'b1;
						pend_r.last_off <= cur_off_r;
						cur_off_r <= cur_off_r + 4'h1;
					end
				end
			end
			default: top_r <= top_r;
			endcase
		end
	end

	always_ff @(negedge scl_link) begin
		if (byte_done && lstate_r == sewp_pkg::L_DATA && ack_nxt &&
			!pend_r.is_lock) begin
			page_buf_r[cur_off_r] <= byte_val;
		end
	end

	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			sda_oe <= 1'b0;
		end else if (start_det) begin
			sda_oe <= 1'b0;
		end else if (byte_done) begin
			sda_oe <= ack_nxt;
		end else if (bitcnt_r == sewp_pkg::ACK_SLOT) begin
			sda_oe <= 1'b0;
		end
	end

	// armed only between an acknowledged data byte and the next bit,
	// which is exactly the tenth slot
	always_ff @(negedge scl_link or negedge rst_b) begin
		if (!rst_b) begin
			stop_ok_r <= 1'b0;
		end else begin
			stop_ok_r <= !start_det && bitcnt_r == sewp_pkg::ACK_SLOT &&
				lstate_r == sewp_pkg::L_DATA && pend_r.ok && sda_oe;
		end
	end

	// system side: stop seen from synchronised levels; pend_r and the
	// page buffer are frozen by then since scl stays high after a stop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			csync1_r <= sewp_pkg::CSYNC_IDLE;
			csync2_r <= sewp_pkg::CSYNC_IDLE;
			cprev_r <= 2'h3;
		end else begin
			csync1_r <= {scl_link, sda_i, stop_ok_r};
			csync2_r <= csync1_r;
			cprev_r <= csync2_r[2:1];
		end
	end
	assign stop_det = csync2_r[2] && cprev_r[1] && csync2_r[1] &&
		!cprev_r[0];
	assign commit = wstate_r == sewp_pkg::W_IDLE && stop_det &&
		csync2_r[0];
	assign done = wstate_r == sewp_pkg::W_BUSY && wcnt_r == WCNT_LAST;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wstate_r <= sewp_pkg::W_IDLE;
			wcnt_r <= '0;
		end else begin
			case (wstate_r)
			sewp_pkg::W_IDLE: begin
				if (commit) begin
					wstate_r <= sewp_pkg::W_BUSY;
					wcnt_r <= '0;
				end
			end
			sewp_pkg::W_BUSY: begin
				if (done) begin
					wstate_r <= sewp_pkg::W_IDLE;
				end else begin
					wcnt_r <= wcnt_r + 1'b1;
				end
			end
			default: wstate_r <= sewp_pkg::W_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			write_busy <= 1'b0;
			desc_r <= '0;
		end else if (commit) begin
			write_busy <= 1'b1;
			desc_r <= pend_r;
		end else if (done) begin
			write_busy <= 1'b0;
		end
	end

	// one buffered byte per cycle; needs WRITE_CYCLES of at least sixteen
	assign widx = wcnt_r[3:0];
	assign wr_en = wstate_r == sewp_pkg::W_BUSY && wcnt_r < WCNT_PAGE &&
		desc_r.mask[widx] && !desc_r.is_lock;

	always_ff @(posedge clk) begin
		if (wr_en && !desc_r.is_ident) begin
			mem_r[{desc_r.page, widx}] <= page_buf_r[widx];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < sewp_pkg::PAGE_BYTES; i++) begin
				id_r[i] <= sewp_pkg::ERASED_BYTE;
			end
			id_r[0] <= ID_MAKER;
			id_r[1] <= ID_FAMILY;
			id_r[2] <= ID_DENSITY;
		end else if (wr_en && desc_r.is_ident) begin
			id_r[widx] <= page_buf_r[widx];
		end
	end

	// no way back to unlocked short of a reset of the model
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ident_locked <= 1'b0;
		end else if (done && desc_r.is_lock && desc_r.lock_req) begin
			ident_locked <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_count <= 9'h000;
		end else if (done && !desc_r.is_lock) begin
			addr_count <= desc_r.is_ident ?
				{5'h00, desc_r.last_off + 4'h1} :
				{desc_r.page, desc_r.last_off} + 9'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sda_o <= 1'b0;
			peek_data <= 8'h00;
		end else begin
			sda_o <= 1'b0;
			peek_data <= peek_ident ? id_r[peek_addr[3:0]] :
				mem_r[peek_addr];
		end
	end

	nomatch_release_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		byte_done && lstate_r == sewp_pkg::L_SEL &&
		!sel_match(byte_val, hi_s, lo_s)
		|=> !sda_oe && lstate_r == sewp_pkg::L_IDLE)
		else $error("unmatched select acknowledged");

	sel_ack_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		byte_done && lstate_r == sewp_pkg::L_SEL && !busy_s &&
		sel_match(byte_val, hi_s, lo_s) |=> sda_oe ##1 !sda_oe)
		else $error("select acknowledge missing or too long");

	addr_ack_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		byte_done && lstate_r == sewp_pkg::L_ADDR
		|=> sda_oe && pend_r.page == {top_r, shift_r[7:4]})
		else $error("address byte not taken");

	wp_nack_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		byte_done && lstate_r == sewp_pkg::L_DATA && wp_s
		|=> !sda_oe && $stable(pend_r.mask))
		else $error("protected data byte accepted");

	lock_nack_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		byte_done && lstate_r == sewp_pkg::L_DATA && pend_r.is_ident &&
		locked_s |=> !sda_oe && !pend_r.ok)
		else $error("locked page data accepted");

	busy_nack_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		busy_s && byte_done && lstate_r == sewp_pkg::L_SEL
		|=> !sda_oe [*2])
		else $error("select acknowledged while busy");

	roll_over_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		byte_done && lstate_r == sewp_pkg::L_DATA && ack_nxt &&
		!pend_r.is_lock |=> cur_off_r == $past(cur_off_r) + 4'h1)
		else $error("in-page offset did not advance");

	abandon_a: assert property (@(negedge scl_link)
		disable iff (!rst_b)
		start_det |=> !pend_r.ok && !stop_ok_r && !sda_oe)
		else $error("start kept pending write");

	commit_cause_a: assert property (@(posedge clk)
		disable iff (!rst_b)
		$rose(write_busy) |-> $past(stop_det) && $past(csync2_r[0]))
		else $error("write cycle without qualifying stop");

	cycle_len_a: assert property (@(posedge clk)
		disable iff (!rst_b)
		$fell(write_busy) |-> $past(wcnt_r) == WCNT_LAST)
		else $error("write cycle length wrong");

	lock_sticky_a: assert property (@(posedge clk)
		disable iff (!rst_b)
		ident_locked |=> ident_locked)
		else $error("ident page unlocked");

	page_full_c: cover property (@(posedge clk) disable iff (!rst_b)
		commit && &pend_r.mask);
	lock_c: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(ident_locked));
	poll_c: cover property (@(negedge scl_link) disable iff (!rst_b)
		busy_s && byte_done && lstate_r == sewp_pkg::L_SEL);
endmodule

// File: sim/sewp_master.sv
`timescale 1ns/10ps
module sewp_master (
	output logic scl,
	output logic sda_pull,
	input wire logic sda_wire
);
	localparam int HALF = 6;
	// scl stands high between frames; sda has a pull-up, so release reads 1
	initial begin
		scl = 1'h1;
		sda_pull = 1'h0;
	end
	task automatic start_c();
		if (scl === 1'h0) begin
			#1 sda_pull = 1'h0;
			#(HALF-1) scl = 1'h1;
		end
		#HALF sda_pull = 1'h1;
		#HALF scl = 1'h0;
	endtask
	// sda moves 1 ns after scl falls so no edge looks like start or stop
	task automatic put_bit(input logic b, output logic seen);
		#1 sda_pull = ~b;
		#(HALF-1) scl = 1'h1;
		#(HALF/2) seen = sda_wire;
		#(HALF/2) scl = 1'h0;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], seen);
		end
		put_bit(1'h1, seen);
		ack = ~seen;
	endtask
	task automatic stop_c();
		#1 sda_pull = 1'h1;
		#(HALF-1) scl = 1'h1;
		#HALF sda_pull = 1'h0;
		#HALF;
	endtask
endmodule

// File: sim/sewp_test.sv
`timescale 1ns/10ps
module sewp_test;
	localparam int WCYC = 40;
	typedef struct {
		logic [7:0] sel;
		logic [7:0] addr;
		int n;
		logic [7:0] d0;
		logic wp;
		logic dack;
		logic pid;
		logic [8:0] pa;
		logic [7:0] pd;
		logic [8:0] cnt;
	} sewp_row_t;
	logic clk;
	logic rst_b;
	logic scl_link;
	logic sda_pull;
	logic sda_i;
	logic sda_o;
	logic sda_oe;
	logic write_protect_in;
	logic chip_sel_hi_pin;
	logic chip_sel_lo_pin;
	logic [8:0] peek_addr;
	logic peek_ident;
	logic [7:0] peek_data;
	logic write_busy;
	logic ident_locked;
	logic [8:0] addr_count;
	int n_fail = 0;
	int samples_checked = 0;
	// ident code values are arbitrary
	logic [7:0] id_exp [4] = '{8'h6B, 8'h1D, 8'hE4, 8'hFF};
	// wrong type, then chip select bits that differ from the straps
	logic [7:0] bad_sel [4] = '{8'h98, 8'hA0, 8'hAC, 8'hB4};
	sewp_row_t rows [7] = '{
		'{8'hA8, 8'h05, 1, 8'h11, 1'h0, 1'h1, 1'h0, 9'h005, 8'h11, 9'h006},
		'{8'hAA, 8'h10, 1, 8'h22, 1'h0, 1'h1, 1'h0, 9'h110, 8'h22, 9'h111},
		'{8'hA8, 8'h2E, 4, 8'h30, 1'h0, 1'h1, 1'h0, 9'h020, 8'h32, 9'h022},
		'{8'hA8, 8'h05, 1, 8'h99, 1'h1, 1'h0, 1'h0, 9'h005, 8'h11, 9'h022},
		'{8'hB8, 8'h73, 1, 8'h44, 1'h0, 1'h1, 1'h1, 9'h003, 8'h44, 9'h004},
		'{8'hB8, 8'h80, 1, 8'h02, 1'h0, 1'h1, 1'h1, 9'h003, 8'h44, 9'h004},
		'{8'hB8, 8'h03, 1, 8'h55, 1'h0, 1'h0, 1'h1, 9'h003, 8'h44, 9'h004}
	};
	assign sda_i = ~(sda_pull | (sda_oe & ~sda_o));
	sewp_master mst_u (
		.scl(scl_link),
		.sda_pull(sda_pull),
		.sda_wire(sda_i)
	);
	sewp_top #(
		.WRITE_CYCLES(WCYC),
		.ID_MAKER(8'h6B),
		.ID_FAMILY(8'h1D),
		.ID_DENSITY(8'hE4)
	) dut_u (
		.clk(clk),
		.rst_b(rst_b),
		.scl_link(scl_link),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.write_protect_in(write_protect_in),
		.chip_sel_hi_pin(chip_sel_hi_pin),
		.chip_sel_lo_pin(chip_sel_lo_pin),
		.peek_addr(peek_addr),
		.peek_ident(peek_ident),
		.peek_data(peek_data),
		.write_busy(write_busy),
		.ident_locked(ident_locked),
		.addr_count(addr_count)
	);
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [8:0] exp,
			input logic [8:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic txn(input logic [7:0] sel, input logic [7:0] addr,
			input int n, input logic [7:0] d0, input logic dack);
		logic a;
		mst_u.start_c();
		mst_u.send_byte(sel, a);
		check("select ack", 9'h001, 9'(a));
		mst_u.send_byte(addr, a);
		check("address ack", 9'h001, 9'(a));
		for (int i = 0; i < n; i++) begin
			mst_u.send_byte(d0 + 8'(i), a);
			check("data ack", 9'(dack), 9'(a));
		end
		mst_u.stop_c();
	endtask
	// sampled at the falling clk edge so busy never races its own update
	task automatic wait_cycle(input logic exp);
		int k;
		k = 0;
		while (write_busy !== 1'h1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		check("write busy", 9'(exp), 9'(write_busy));
		k = 0;
		while (write_busy === 1'h1 && k < WCYC + 10) begin
			@(negedge clk);
			k++;
		end
		if (exp === 1'h1) begin
			check("busy length", 9'h001, 9'(k >= WCYC - 1 && k <= WCYC + 1));
		end
	endtask
	task automatic peek(input logic pid, input logic [8:0] pa,
			input logic [7:0] exp);
		@(negedge clk);
		peek_ident = pid;
		peek_addr = pa;
		repeat (2) @(negedge clk);
		check("peek data", 9'(exp), 9'(peek_data));
	endtask
	initial begin
		#200000;
		n_fail++;
		$display("watchdog expired");
		final_report();
	end
	initial begin
		logic a;
		int k;
		rst_b = 1'h0;
		write_protect_in = 1'h0;
		chip_sel_hi_pin = 1'h1;
		chip_sel_lo_pin = 1'h0;
		peek_addr = 9'h000;
		peek_ident = 1'h0;
		repeat (4) @(negedge clk);
		rst_b = 1'h1;
		check("count reset", 9'h000, addr_count);
		check("lock reset", 9'h000, 9'(ident_locked));
		for (int i = 0; i < 4; i++) begin
			peek(1'h1, 9'(i), id_exp[i]);
		end
		$display("reset test done");
		// the lock row follows the ident write, as a master should do it
		foreach (rows[i]) begin
			@(negedge clk);
			write_protect_in = rows[i].wp;
			txn(rows[i].sel, rows[i].addr, rows[i].n, rows[i].d0, rows[i].dack);
			wait_cycle(rows[i].dack);
			peek(rows[i].pid, rows[i].pa, rows[i].pd);
			check("addr count", rows[i].cnt, addr_count);
			$display("row %0d done", i);
		end
		check("ident locked", 9'h001, 9'(ident_locked));
		peek(1'h0, 9'h02F, 8'h31);
		foreach (bad_sel[i]) begin
			mst_u.start_c();
			mst_u.send_byte(bad_sel[i], a);
			check("foreign select", 9'h000, 9'(a));
			mst_u.send_byte(8'hA8, a);
			check("idle after nack", 9'h000, 9'(a));
			mst_u.stop_c();
		end
		mst_u.start_c();
		mst_u.send_byte(8'hA9, a);
		check("read select", 9'h001, 9'(a));
		mst_u.stop_c();
		$display("select test done");
		txn(8'hA8, 8'h40, 1, 8'h77, 1'h1);
		k = 0;
		a = 1'h0;
		while (a !== 1'h1 && k < 40) begin
			mst_u.start_c();
			mst_u.send_byte(8'hA8, a);
			if (k == 0) begin
				check("busy select", 9'h000, 9'(a));
			end
			k++;
		end
		check("poll ack", 9'h001, 9'(a));
		mst_u.send_byte(8'h41, a);
		mst_u.send_byte(8'h78, a);
		mst_u.stop_c();
		wait_cycle(1'h1);
		peek(1'h0, 9'h040, 8'h77);
		peek(1'h0, 9'h041, 8'h78);
		$display("poll test done");
		mst_u.start_c();
		mst_u.send_byte(8'hA8, a);
		mst_u.send_byte(8'h50, a);
		mst_u.stop_c();
		wait_cycle(1'h0);
		mst_u.start_c();
		mst_u.send_byte(8'hA8, a);
		mst_u.send_byte(8'h50, a);
		mst_u.send_byte(8'h66, a);
		mst_u.start_c();
		mst_u.stop_c();
		wait_cycle(1'h0);
		$display("abort test done");
		@(negedge clk);
		rst_b = 1'h0;
		repeat (4) @(negedge clk);
		rst_b = 1'h1;
		check("lock after reset", 9'h000, 9'(ident_locked));
		check("count after reset", 9'h000, addr_count);
		check("busy after reset", 9'h000, 9'(write_busy));
		peek(1'h1, 9'h003, 8'hFF);
		$display("second reset done");
		final_report();
	end
endmodule
